// ==== rtl/sfr_rx_term.sv ====
// Purpose: receiving path terminal for an STS-1 byte stream
// Assumes: sender keeps frame order and marks each frame's first byte with sof
// Notes: classifies every byte, tracks the floating envelope through its pointer
`timescale 1ns/1ps
module sfr_rx_term
  import sfr_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  sfr_link_if.rx link,
  input wire logic usr_ready,
  output logic valid_q,
  output logic [7:0] data_q,
  output sfr_kind_t kind_q,
  output logic frame_start_q,
  output logic [3:0] row_out_q,
  output logic [6:0] col_out_q,
  output logic dcc_q,
  output logic spe_start_q,
  output logic [9:0] ptr_q,
  output logic ptr_ok_q,
  output logic ptr_inc_q,
  output logic ptr_dec_q,
  output logic ndf_q,
  output logic align_err_q
);
  logic [8:0] buf_out;
  logic buf_valid, take, b_sof;
  logic [7:0] b_byte;
  logic [3:0] row_q, r_cur, r_nxt;
  logic [6:0] col_q, c_cur, c_nxt;
  logic [9:0] env_q, e_cur, rx_ptr, cand_q;
  logic [6:0] spe_q, s_cur;
  logic [7:0] h1_q;
  logic [1:0] seen_q;
  logic [3:0] ndf_bits;
  logic [2:0] flip_i, flip_d;
  logic inc_fr_q, dec_fr_q;
  logic in_toh, in_env, frame_first, is_stuff, h3_data, spe_hit, at_h2;
  sfr_kind_t kind_d;

  // counts pointer bits that differ from the held pointer, odd or even half
  function automatic logic [2:0] flips(input logic [9:0] a, input logic [9:0] b,
                                       input logic odd);
    logic [2:0] n;
    n = '0;
    for (int k = 0; k < PTR_HALF; k++)
      n = n + 3'(a[2 * k + int'(odd)] ^ b[2 * k + int'(odd)]);
    return n;
  endfunction

  // the buffer absorbs a user stall so the link never drops a byte
  sfr_buf2 #(.WIDTH(9), .DEPTH(2)) u_buf (
    .clk(clk),
    .reset_n(reset_n),
    .in_data({link.sof, link.data}),
    .in_valid(link.valid),
    .in_ready(link.ready),
    .out_data(buf_out),
    .out_valid(buf_valid),
    .out_ready(take)
  );

  assign take = buf_valid && (!valid_q || usr_ready);
  assign b_sof = buf_out[8];
  assign b_byte = buf_out[7:0];

  always_comb
  begin
    // a marked byte forces the position back to the frame origin
    r_cur = b_sof ? '0 : row_q;
    c_cur = b_sof ? '0 : col_q;
    if (c_cur == COL_LAST)
    begin
      c_nxt = '0;
      r_nxt = (r_cur == ROW_LAST) ? '0 : r_cur + 4'h1;
    end
    else
    begin
      c_nxt = c_cur + 7'h1;
      r_nxt = r_cur;
    end
    frame_first = (r_cur == '0) && (c_cur == '0);
    in_toh = (c_cur <= TOH_LAST);
    in_env = !in_toh;
    is_stuff = inc_fr_q && (r_cur == PTR_ROW) && (c_cur == ENV_FIRST);
    h3_data = dec_fr_q && (r_cur == PTR_ROW) && (c_cur == H3_COL);
    // envelope offset zero is the byte right after the action byte
    e_cur = ((r_cur == PTR_ROW) && (c_cur == ENV_FIRST)) ? '0 : env_q;
    spe_hit = ptr_ok_q && in_env && !is_stuff && (e_cur == ptr_q);
    s_cur = spe_hit ? '0 : spe_q;
    if (in_toh)
      kind_d = h3_data ? SFR_PAY : SFR_TOH;
    else if (is_stuff)
      kind_d = SFR_STUFF;
    else if (s_cur == '0)
      kind_d = SFR_POH;
    else
      kind_d = SFR_PAY;
  end

  // position counters
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      row_q <= '0;
      col_q <= '0;
      env_q <= '0;
      spe_q <= '0;
    end
    else if (take)
    begin
      row_q <= r_nxt;
      col_q <= c_nxt;
      if (in_env)
        env_q <= (e_cur == ENV_LAST) ? '0 : e_cur + 10'h1;
      if ((in_env && !is_stuff) || h3_data)
        spe_q <= (s_cur == SPE_COL_LAST) ? '0 : s_cur + 7'h1;
    end
  end

  assign rx_ptr = {h1_q[1:0], b_byte};
  assign ndf_bits = h1_q[7:4];
  assign flip_i = flips(rx_ptr, ptr_q, 1'b1);
  assign flip_d = flips(rx_ptr, ptr_q, 1'b0);
  assign at_h2 = take && (r_cur == PTR_ROW) && (c_cur == H2_COL);

  // pointer interpretation
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      h1_q <= '0;
      ptr_q <= '0;
      ptr_ok_q <= 1'b0;
      cand_q <= '0;
      seen_q <= '0;
      inc_fr_q <= 1'b0;
      dec_fr_q <= 1'b0;
      ptr_inc_q <= 1'b0;
      ptr_dec_q <= 1'b0;
      ndf_q <= 1'b0;
    end
    else
    begin
      ptr_inc_q <= 1'b0;
      ptr_dec_q <= 1'b0;
      ndf_q <= 1'b0;
      if (take && (r_cur == PTR_ROW) && (c_cur == H1_COL))
        h1_q <= b_byte;
      if (take && frame_first)
      begin
        inc_fr_q <= 1'b0;
        dec_fr_q <= 1'b0;
      end
      if (at_h2)
      begin
        if ((ndf_bits == NDF_SET) && (rx_ptr <= PTR_MAX))
        begin
          // new data flag: jump at once, no persistence wait
          ptr_q <= rx_ptr;
          ptr_ok_q <= 1'b1;
          ndf_q <= 1'b1;
          seen_q <= '0;
        end
        else if (ptr_ok_q && (ndf_bits == NDF_NORM) && (flip_i >= PTR_MAJ)
                 && (flip_d < PTR_MAJ))
        begin
          ptr_q <= (ptr_q == PTR_MAX) ? '0 : ptr_q + 10'h1;
          ptr_inc_q <= 1'b1;
          inc_fr_q <= 1'b1;
        end
        else if (ptr_ok_q && (ndf_bits == NDF_NORM) && (flip_d >= PTR_MAJ)
                 && (flip_i < PTR_MAJ))
        begin
          ptr_q <= (ptr_q == '0) ? PTR_MAX : ptr_q - 10'h1;
          ptr_dec_q <= 1'b1;
          dec_fr_q <= 1'b1;
        end
        else if ((ndf_bits == NDF_NORM) && (rx_ptr <= PTR_MAX))
        begin
          // a changed pointer must repeat before it is believed
          if (rx_ptr == cand_q)
          begin
            if (seen_q == PTR_AGREE_LAST)
            begin
              ptr_q <= rx_ptr;
              ptr_ok_q <= 1'b1;
            end
            else
              seen_q <= seen_q + 2'h1;
          end
          else
          begin
            cand_q <= rx_ptr;
            seen_q <= 2'h1;
          end
        end
      end
    end
  end

  // user side output stage
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      valid_q <= 1'b0;
      data_q <= '0;
      kind_q <= SFR_TOH;
      frame_start_q <= 1'b0;
      row_out_q <= '0;
      col_out_q <= '0;
      dcc_q <= 1'b0;
      spe_start_q <= 1'b0;
      align_err_q <= 1'b0;
    end
    else
    begin
      align_err_q <= take && (b_sof != ((row_q == '0) && (col_q == '0)));
      if (take)
      begin
        valid_q <= 1'b1;
        data_q <= b_byte;
        kind_q <= kind_d;
        frame_start_q <= frame_first;
        row_out_q <= r_cur;
        col_out_q <= c_cur;
        dcc_q <= in_toh && ((r_cur == DCC_SEC_ROW) ||
                 ((r_cur >= DCC_LINE_FIRST) && (r_cur <= DCC_LINE_LAST)));
        spe_start_q <= spe_hit;
      end
      else if (usr_ready)
        valid_q <= 1'b0;
    end
  end
endmodule // sfr_rx_term

// ==== pkg/sfr_pkg.sv ====
// Purpose: shared constants and types for the STS-1 frame link and its two ends
// Assumes: one 100 MHz clock, one byte per link transfer
// Notes: positions are zero based; row 0, column 0 is the first byte of a frame
package sfr_pkg;
  localparam int unsigned FRAME_BYTES = 810;
  localparam int unsigned FRAME_BITS = 6480;
  localparam int unsigned FRAMES_PER_S = 8000;
  localparam int unsigned CLK_NS = 10;
  localparam int unsigned FRAME_NS = 1000000000 / FRAMES_PER_S;
  localparam int unsigned CYC_PER_FRAME = FRAME_NS / CLK_NS;
  localparam logic [13:0] PACE_STEP = 14'(FRAME_BYTES);
  localparam logic [13:0] PACE_WRAP = 14'(CYC_PER_FRAME);
  // frame array: 9 rows of 90 columns
  localparam logic [3:0] ROW_LAST = 4'h8;
  localparam logic [6:0] COL_LAST = 7'h59;
  // transport overhead columns 0..2, envelope from column 3
  localparam logic [6:0] TOH_LAST = 7'h2;
  localparam logic [6:0] ENV_FIRST = 7'h3;
  localparam logic [6:0] SPE_COL_LAST = 7'h56;
  localparam logic [9:0] ENV_LAST = 10'h30E;
  // pointer bytes sit in row 3 of the overhead
  localparam logic [3:0] PTR_ROW = 4'h3;
  localparam logic [6:0] H1_COL = 7'h0;
  localparam logic [6:0] H2_COL = 7'h1;
  localparam logic [6:0] H3_COL = 7'h2;
  localparam logic [9:0] PTR_MAX = 10'h30E;
  localparam logic [3:0] NDF_NORM = 4'h6;
  localparam logic [3:0] NDF_SET = 4'h9;
  localparam int unsigned PTR_HALF = 5;
  localparam logic [2:0] PTR_MAJ = 3'h3;
  localparam logic [1:0] PTR_AGREE_LAST = 2'h2;
  // data communication channel rows within the overhead
  localparam logic [3:0] DCC_SEC_ROW = 4'h2;
  localparam logic [3:0] DCC_LINE_FIRST = 4'h5;
  localparam logic [3:0] DCC_LINE_LAST = 4'h7;
  // framing pattern and filler
  localparam logic [7:0] FRAME_A = 8'hF6;
  localparam logic [7:0] FRAME_B = 8'h28;
  localparam logic [7:0] FILL_BYTE = 8'h00;
  localparam logic [3:0] A_ROW = 4'h0;
  localparam logic [6:0] A1_COL = 7'h0;
  localparam logic [6:0] A2_COL = 7'h1;

  typedef enum logic [1:0] {SFR_TOH, SFR_POH, SFR_PAY, SFR_STUFF} sfr_kind_t;
endpackage

// ==== pkg/sfr_link_if.sv ====
// Purpose: byte link between the frame sender and the receiving terminal
// Assumes: both ends on the same clock; data, sof held while valid and not ready
// Notes: sof marks the first byte of every frame
`timescale 1ns/1ps
interface sfr_link_if;
  logic [7:0] data;
  logic sof;
  logic valid;
  logic ready;
  modport tx (output data, output sof, output valid, input ready);
  modport rx (input data, input sof, input valid, output ready);
endinterface

// ==== rtl/sfr_buf2.sv ====
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: DEPTH is a power of two
// Notes: full back-pressure, no word lost while the drain side stalls
`timescale 1ns/1ps
module sfr_buf2 #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wp_q, rp_q;
  logic [CW-1:0] cnt_q;
  logic wr, rd;

  assign in_ready = (cnt_q != FULL);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rp_q];
  assign wr = in_valid && in_ready;
  assign rd = out_valid && out_ready;

  for (genvar g = 0; g < DEPTH; g++)
  begin : g_entry
    always_ff @(posedge clk)
    begin
      if (wr && (wp_q == PW'(g)))
        mem_q[g] <= in_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (wr)
        wp_q <= wp_q + PW'(1);
      if (rd)
        rp_q <= rp_q + PW'(1);
      if (wr && !rd)
        cnt_q <= cnt_q + CW'(1);
      else if (rd && !wr)
        cnt_q <= cnt_q - CW'(1);
    end
  end
endmodule // sfr_buf2

// ==== rtl/sfr_tx_elem.sv ====
// Purpose: STS-1 frame sender facing the receiving terminal
// Assumes: user supplies envelope bytes in order, POH already placed by the user
// Notes: pacing gives 810 byte slots per 12500 clocks; a held link loses slots
`timescale 1ns/1ps
module sfr_tx_elem
  import sfr_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  sfr_link_if.tx link,
  input wire logic [9:0] ptr_cfg,
  input wire logic [7:0] pay_data,
  input wire logic pay_valid,
  output logic pay_ready,
  input wire logic [7:0] dcc_data,
  output logic dcc_take
);
  logic [13:0] acc_q, acc_sum;
  logic credit_q, tick, load;
  logic [3:0] row_q;
  logic [6:0] col_q;
  logic [7:0] byte_d;
  logic valid_q, sof_q;
  logic [7:0] data_q;
  logic in_toh, is_dcc;

  assign acc_sum = acc_q + PACE_STEP;
  assign tick = (acc_sum >= PACE_WRAP);
  assign load = credit_q && (!valid_q || link.ready);
  assign in_toh = (col_q <= TOH_LAST);
  assign is_dcc = in_toh && ((row_q == DCC_SEC_ROW) ||
                  ((row_q >= DCC_LINE_FIRST) && (row_q <= DCC_LINE_LAST)));
  assign pay_ready = load && !in_toh;
  assign dcc_take = load && is_dcc;
  assign link.valid = valid_q;
  assign link.data = data_q;
  assign link.sof = sof_q;

  always_comb
  begin
    byte_d = FILL_BYTE;
    if (!in_toh)
      byte_d = pay_valid ? pay_data : FILL_BYTE;
    else if (is_dcc)
      byte_d = dcc_data;
    else if ((row_q == A_ROW) && (col_q == A1_COL))
      byte_d = FRAME_A;
    else if ((row_q == A_ROW) && (col_q == A2_COL))
      byte_d = FRAME_B;
    else if ((row_q == PTR_ROW) && (col_q == H1_COL))
      byte_d = {NDF_NORM, 2'h0, ptr_cfg[9:8]};
    else if ((row_q == PTR_ROW) && (col_q == H2_COL))
      byte_d = ptr_cfg[7:0];
  end

  // slot pacing
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      acc_q <= '0;
      credit_q <= 1'b0;
    end
    else
    begin
      acc_q <= tick ? acc_sum - PACE_WRAP : acc_sum;
      if (tick)
        credit_q <= 1'b1;
      else if (load)
        credit_q <= 1'b0;
    end
  end

  // byte order and link output
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      row_q <= '0;
      col_q <= '0;
      valid_q <= 1'b0;
      sof_q <= 1'b0;
      data_q <= '0;
    end
    else if (load)
    begin
      valid_q <= 1'b1;
      data_q <= byte_d;
      sof_q <= (row_q == '0) && (col_q == '0);
      if (col_q == COL_LAST)
      begin
        col_q <= '0;
        row_q <= (row_q == ROW_LAST) ? '0 : row_q + 4'h1;
      end
      else
        col_q <= col_q + 7'h1;
    end
    else if (link.ready)
      valid_q <= 1'b0;
  end
endmodule // sfr_tx_elem

// ==== dv/sfr_link_asserts.sv ====
// Purpose: link-level checks on the STS-1 byte link between the two ends
// Assumes: one clock, synchronous active-low reset
// Notes: the position count moves on taken bytes only, so a held byte never advances it
`timescale 1ns/1ps
module sfr_link_asserts
  import sfr_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] data,
  input wire logic sof,
  input wire logic valid,
  input wire logic ready
);
  logic [9:0] pos_q;
  wire logic take = valid && ready;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      pos_q <= 10'h000;
    else if (take)
      pos_q <= (pos_q == 10'h329) ? 10'h000 : pos_q + 10'h001;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  hold_until_taken_a: assert property (valid && !ready |=> valid && $stable(data) && $stable(sof))
    else $error("link byte changed while held");
  frame_length_a: assert property (take && sof |-> pos_q == 10'h000)
    else $error("frame start not after 810 bytes");
  next_frame_a: assert property (take && pos_q == 10'h000 |-> sof)
    else $error("byte after frame end not marked as frame start");
  sync_first_a: assert property (valid && sof |-> data == FRAME_A)
    else $error("first framing byte wrong");
  sync_second_a: assert property (take && pos_q == 10'h001 |-> data == FRAME_B)
    else $error("second framing byte wrong");
  ptr_action_a: assert property (take && pos_q == 10'h110 |-> data == 8'h00)
    else $error("pointer action byte not idle");
  ptr_flag_a: assert property (take && pos_q == 10'h10E |->
    data[7:4] == NDF_NORM || data[7:4] == NDF_SET)
    else $error("pointer flag nibble invalid");
  pace_gap_a: assert property ($rose(valid) && ready |=> !valid [*8])
    else $error("bytes sent faster than the line rate");
  pace_next_a: assert property (take |-> ##[1:20] valid)
    else $error("line slot missed without a stall");

  cover property (take && sof);
  cover property (valid && !ready);
  cover property (take && pos_q == 10'h329);
endmodule // sfr_link_asserts

// ==== dv/sts1_frame_structure_framer_bench.sv ====
// Purpose: both ends joined over the link; checks frame map, envelope and pointer
// Assumes: sender pointer fixed, user envelope and channel bytes are running counts
// Notes: a long receive stall fills the buffer so the sender has to hold its byte
`timescale 1ns/1ps
module sts1_frame_structure_framer_bench;
  import sfr_pkg::*;
  localparam logic [9:0] PTR_SET = 10'h1F4;
  logic clk, reset_n, usr_ready, pay_valid, pay_took, dcc_took, pay_ready, dcc_take;
  logic valid_q, frame_start_q, dcc_q, spe_start_q, ptr_ok_q, ptr_inc_q, ptr_dec_q, ndf_q;
  logic align_err_q;
  logic [9:0] ptr_cfg, ptr_q;
  logic [7:0] pay_data, dcc_data, data_q;
  logic [3:0] row_out_q;
  logic [6:0] col_out_q;
  sfr_kind_t kind_q;
  int fails, checks;

  sfr_link_if lnk();
  sfr_tx_elem i_sfr_tx_elem(.clk(clk), .reset_n(reset_n), .link(lnk), .ptr_cfg(ptr_cfg),
    .pay_data(pay_data), .pay_valid(pay_valid), .pay_ready(pay_ready),
    .dcc_data(dcc_data), .dcc_take(dcc_take));
  sfr_rx_term i_sfr_rx_term(.clk(clk), .reset_n(reset_n), .link(lnk), .usr_ready(usr_ready),
    .valid_q(valid_q), .data_q(data_q), .kind_q(kind_q), .frame_start_q(frame_start_q),
    .row_out_q(row_out_q), .col_out_q(col_out_q), .dcc_q(dcc_q), .spe_start_q(spe_start_q),
    .ptr_q(ptr_q), .ptr_ok_q(ptr_ok_q), .ptr_inc_q(ptr_inc_q), .ptr_dec_q(ptr_dec_q),
    .ndf_q(ndf_q), .align_err_q(align_err_q));
  sfr_link_asserts i_sfr_link_asserts(.clk(clk), .reset_n(reset_n), .data(lnk.data),
    .sof(lnk.sof), .valid(lnk.valid), .ready(lnk.ready));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // consumed pulses are combinational, so sample them away from the edge
  always @(negedge clk)
  begin
    pay_took = pay_ready;
    dcc_took = dcc_take;
  end
  // running counts restart with reset, so one process owns them
  always @(posedge clk)
  begin
    #1;
    if (!reset_n)
    begin
      pay_data = 8'h00;
      dcc_data = 8'h00;
    end
    else
    begin
      if (pay_took)
        pay_data = pay_data + 8'h01;
      if (dcc_took)
        dcc_data = dcc_data + 8'h01;
    end
  end

  task check_val(input logic [9:0] got, input logic [9:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task check_bit(input logic got, input logic exp);
    check_val({9'h000, got}, {9'h000, exp});
  endtask

  task end_of_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task scen_link_frame;
    int n, cyc;
    bit on, done;
    n = 0; cyc = 0; on = 0; done = 0;
    while (!done && cyc < 30000)
    begin
      @(posedge clk); #1; cyc++;
      if (lnk.valid && lnk.ready)
      begin
        if (lnk.sof && on)
        begin
          check_val(10'(n), 10'h32A);
          done = 1;
        end
        if (lnk.sof && !on)
        begin
          check_val({2'h0, lnk.data}, {2'h0, FRAME_A});
          on = 1;
        end
        if (on) n++;
      end
    end
    check_bit(done, 1'b1);
  endtask

  // envelope and channel bytes must arrive as unbroken counts: no byte lost or repeated
  task scen_frame_map(input bit stall, input bit ptrchk);
    int r, c, n, cyc, o, rel;
    logic [7:0] ep, ed;
    bit ps, ds;
    r = 0; c = 0; n = 0; cyc = 0; ps = 0; ds = 0;
    if (ptrchk)
    begin
      while (!ptr_ok_q && cyc < 40000)
      begin
        @(posedge clk); #1; cyc++;
      end
      check_bit(ptr_ok_q, 1'b1);
      check_val(ptr_q, PTR_SET);
      cyc = 0;
    end
    while (n < 810 && cyc < 30000)
    begin
      @(posedge clk); #1; cyc++;
      usr_ready = !stall || (cyc % 900 > 80);
      if (ptrchk) check_bit(ptr_inc_q | ptr_dec_q | ndf_q | align_err_q, 1'b0);
      if (valid_q && usr_ready && (n > 0 || frame_start_q))
      begin
        check_val({6'h00, row_out_q}, 10'(r));
        check_val({3'h0, col_out_q}, 10'(c));
        check_bit(frame_start_q, r == 0 && c == 0);
        check_bit(kind_q == SFR_TOH, c < 3);
        check_bit(dcc_q, c < 3 && (r == 2 || (r >= 5 && r <= 7)));
        if (c >= 3)
        begin
          if (ps) check_val({2'h0, data_q}, {2'h0, ep});
          ep = data_q + 8'h01;
          ps = 1;
          o = ((r + 6) % 9) * 87 + c - 3;
          rel = (o + 783 - int'(PTR_SET)) % 783;
          if (ptrchk) check_bit(spe_start_q, rel == 0);
          if (ptrchk) check_bit(kind_q == SFR_POH, rel % 87 == 0);
        end
        if (dcc_q === 1'b1)
        begin
          if (ds) check_val({2'h0, data_q}, {2'h0, ed});
          ed = data_q + 8'h01;
          ds = 1;
        end
        n++;
        c++;
        if (c == 90)
        begin
          c = 0;
          r++;
        end
      end
    end
    usr_ready = 1'b1;
    check_val(10'(n), 10'h32A);
  endtask

  task scen_reset;
    @(posedge clk); #1;
    reset_n = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check_bit(valid_q, 1'b0);
    check_bit(ptr_ok_q, 1'b0);
    check_bit(lnk.valid, 1'b0);
    reset_n = 1'b1;
    @(posedge clk);
    #1;
    check_bit(lnk.ready, 1'b1);
    check_bit(kind_q == SFR_TOH, 1'b1);
  endtask

  initial
  begin
    reset_n = 1'b0;
    usr_ready = 1'b1;
    pay_valid = 1'b1;
    ptr_cfg = PTR_SET;
    fails = 0;
    checks = 0;
    repeat (20) @(posedge clk);
    #1;
    reset_n = 1'b1;
    scen_link_frame;
    scen_frame_map(1'b0, 1'b0);
    scen_frame_map(1'b1, 1'b0);
    scen_frame_map(1'b0, 1'b1);
    scen_reset;
    end_of_test;
  end

  initial
  begin
    // four frames of 12500 cycles plus waits and stall losses need a little over 50000
    repeat (80000) @(posedge clk);
    fails++;
    end_of_test;
  end
endmodule // sts1_frame_structure_framer_bench
